// [bench/pcs_checker.sv]
`timescale 1ns/100ps
module pcs_checker (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic id_word120_bit7_o,
    input wire logic [1:0] timer_run_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    logic [3:0] since_b_r;
    // cycles since the last write response, saturating
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) since_b_r <= 4'hF;
        else if (s_axi_bvalid && s_axi_bready) since_b_r <= 4'h0;
        else if (since_b_r != 4'hF) since_b_r <= since_b_r + 4'h1;
    end
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_write_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
        else $error("write not answered");
    a_read_answer: assert property (s_rd_taken |-> ##2 s_axi_rvalid)
        else $error("read not answered");
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped");
    a_bresp_stable: assert property (s_axi_bvalid && !s_axi_bready |=> $stable(s_axi_bresp))
        else $error("bresp moved");
    a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("rvalid dropped");
    a_rdata_stable: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
        else $error("rdata moved");
    a_id_after_cmd: assert property ($changed(id_word120_bit7_o) && $past(rst_n_i) &&
        $past(rst_n_i, 2) && $past(rst_n_i, 3) |-> since_b_r <= 4'h8)
        else $error("identify bit moved without command");
    a_run_needs_en: assert property (|timer_run_o |-> id_word120_bit7_o ||
        $past(id_word120_bit7_o))
        else $error("timer runs while feature disabled");
endmodule : pcs_checker
bind pcs_handler pcs_checker i_chk (.clock_i, .rst_n_i, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
    .id_word120_bit7_o, .timer_run_o);

// [bench/pcs_host_model.sv]
`timescale 1ns/100ps
`include "pcs_defines.svh"
module pcs_host_model (
    input wire logic clock_i,
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    localparam logic [7:0] FEAT_PWR = 8'h4A;
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta;
        logic tw;
        ta = 1'b0;
        tw = 1'b0;
        @(posedge clock_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(ta && tw)) begin
            @(posedge clock_i);
            if (!ta && s_axi_awready === 1'b1) begin
                ta = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!tw && s_axi_wready === 1'b1) begin
                tw = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge clock_i); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clock_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clock_i); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge clock_i); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd
    // issue one power-condition subcommand and poll until the device is not busy
    task automatic cmd(input logic [7:0] sec, input logic [7:0] cond, output logic [31:0] st);
        logic [1:0] r;
        int n;
        wr(`PCS_ADDR_CMD, {8'h00, sec, cond, FEAT_PWR});
        n = 0;
        do begin
            rd(`PCS_ADDR_STAT, st, r);
            n++;
        end while (st[7] !== 1'b0 && n < 20);
    endtask : cmd
endmodule : pcs_host_model

// [bench/tb_top.sv]
`timescale 1ns/100ps
`include "pcs_defines.svh"
module tb_top;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r, timer_run_o, timer_expired_o;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic id_word120_bit7_o, advanced_power_management_en_o;
    int num_errors = 0;
    int compares = 0;
    localparam logic [31:0] OK = {16'h0, 8'h00, `PCS_ST_OK};
    localparam logic [31:0] AB = {16'h0, `PCS_ERR_ABT, `PCS_ST_ERR};
    logic [15:0] t_in [4] = '{16'h1234, 16'hFFFF, 16'h0010, 16'h0000};
    logic [7:0] t_sec [4] = '{8'h32, 8'hA2, 8'hA2, 8'h22};
    logic [31:0] t_exp [4] = '{32'hC0001234, 32'hC03BFFC4, 32'hC0002580, 32'h40000000};
    always #12.5 clock_i = ~clock_i;
    pcs_handler #(.TICK_CYC(4)) i_dut (.clock_i, .rst_n_i, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .id_word120_bit7_o, .advanced_power_management_en_o, .timer_run_o, .timer_expired_o);
    pcs_host_model i_host (.clock_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        compares++;
        if (s !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic sub(input logic [7:0] sec, input logic [7:0] c, input logic [31:0] e);
        i_host.cmd(sec, c, d);
        chk("status", e, {16'h0, d[15:0]});
    endtask : sub
    task automatic data(input logic [7:0] c, input logic [31:0] m, input logic [31:0] e);
        i_host.wr(`PCS_ADDR_SEL, {24'h0, c});
        i_host.rd(`PCS_ADDR_DATA, d, r);
        chk("data", e, d & m);
    endtask : data
    task automatic finish_test;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : finish_test
    initial begin
        #(25 * 20000);
        num_errors++;
        finish_test();
    end
    initial begin
        repeat (16) @(posedge clock_i);
        rst_n_i <= 1'b1;
        i_host.wr(`PCS_ADDR_CTRL, 32'h1);
        i_host.rd(`PCS_ADDR_CTRL, d, r);
        chk("ctrl", 32'h9, d & 32'hF);
        sub(8'h05, 8'h0, AB);
        sub(8'h32, 8'h0, AB);
        sub(8'h04, 8'h0, OK);
        chk("id", 32'h1, {31'h0, id_word120_bit7_o});
        chk("apm", 32'h0, {31'h0, advanced_power_management_en_o});
        data(8'h0, 32'h003FFFFF, 32'h64);
        for (int i = 0; i < 4; i++) begin
            i_host.wr(`PCS_ADDR_TIMER, {16'h0, t_in[i]});
            sub(t_sec[i], 8'h0, OK);
            data(8'h0, 32'hC03FFFFF, t_exp[i]);
        end
        sub(8'h33, 8'h1, OK);
        data(8'h1, 32'hC0000000, 32'hC0000000);
        sub(8'h03, 8'h1, OK);
        data(8'h1, 32'hC0000000, 32'h40000000);
        i_host.wr(`PCS_ADDR_COND, 32'h00010303);
        sub(8'h13, 8'h1, AB);
        data(8'h1, 32'hC0000000, 32'h40000000);
        i_host.wr(`PCS_ADDR_COND, 32'h00030103);
        i_host.wr(`PCS_ADDR_TIMER, 32'h5);
        sub(8'h22, 8'h1, AB);
        data(8'h1, 32'hC03FFFFF, 32'h40000064);
        i_host.wr(`PCS_ADDR_COND, 32'h00030302);
        sub(8'h23, 8'h0, AB);
        i_host.wr(`PCS_ADDR_COND, 32'h00030303);
        sub(8'h23, 8'h0, OK);
        i_host.wr(`PCS_ADDR_TIMER, 32'h1);
        sub(8'h32, 8'h1, OK);
        sub(8'h04, 8'h0, OK);
        data(8'h0, 32'h003FFFFF, 32'h1234);
        chk("run", 32'h1, {30'h0, timer_run_o});
        chk("expired", 32'h2, {30'h0, timer_expired_o});
        @(posedge clock_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        chk("id reset", 32'h1, {31'h0, id_word120_bit7_o});
        i_host.wr(`PCS_ADDR_CTRL, 32'h1);
        sub(8'h05, 8'h0, OK);
        chk("id off", 32'h0, {31'h0, id_word120_bit7_o});
        chk("run off", 32'h0, {30'h0, timer_run_o});
        sub(8'h05, 8'h0, AB);
        i_host.wr(`PCS_ADDR_CTRL, 32'h0);
        sub(8'h04, 8'h0, AB);
        i_host.rd(8'h1C, d, r);
        chk("slverr", 32'h2, {30'h0, r});
        finish_test();
    end
endmodule : tb_top

// [hw/pcs_defines.svh]
// What this block does
// - timer units bit picks 100ms or minute
// - timer from cylinder bytes, clamped to limits
// - limits are 3BFFC4h and zero
// - code 2h sets timer, enable/save flags
// - abort timer set if disabled/unchangeable/unsavable
// - abort out-of-range timer when not clamped; code always clamps, so never aborts
// - aborted request leaves settings untouched
// - code 3h sets state, enable/save flags
// - state set enables or disables current timer
// - save copies current enabled to saved
// - abort state set on same conditions
// - code 4h enables the feature set
// - enable sets identify bit, disables power management
// - enable loads current from saved or default
// - enable starts enabled non-zero timers
// - abort enable when feature set unsupported
// - code 5h disables the feature set
// - disable stops timers, clears identify bit
// - enabled state survives all resets
// - abort disable when disabled or unsupported
// - timer set copies value, enables if enable flag set and non-zero
// - save copies current timer to saved
`ifndef PCS_DEFINES_SVH
`define PCS_DEFINES_SVH
`define PCS_ADDR_CMD 8'h00
`define PCS_ADDR_TIMER 8'h04
`define PCS_ADDR_CTRL 8'h08
`define PCS_ADDR_STAT 8'h0C
`define PCS_ADDR_COND 8'h10
`define PCS_ADDR_SEL 8'h14
`define PCS_ADDR_DATA 8'h18
`define PCS_NCOND 2
`define PCS_SUB_TIMER 4'h2
`define PCS_SUB_STATE 4'h3
`define PCS_SUB_ENA 4'h4
`define PCS_SUB_DIS 4'h5
`define PCS_BIT_UNITS 7
`define PCS_BIT_EN 5
`define PCS_BIT_SAVE 4
`define PCS_TMR_MAX 32'h003BFFC4
`define PCS_TMR_MIN 32'h00000000
`define PCS_TMR_DEF 32'h00000064
`define PCS_MIN_TO_UNITS 32'h00000258
`define PCS_ERR_ABT 8'h04
`define PCS_ST_OK 8'h40
`define PCS_ST_ERR 8'h41
`define PCS_ST_BSY 8'h80
`define PCS_TICK_MS 100
`define PCS_CLK_KHZ 40000
`define PCS_TICK_CYC (`PCS_TICK_MS * `PCS_CLK_KHZ)
`endif

// [hw/pcs_handler.sv]
`timescale 1ns/100ps
`include "pcs_defines.svh"
module pcs_handler #(
    parameter int TICK_CYC = `PCS_TICK_CYC
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic id_word120_bit7_o,
    output logic advanced_power_management_en_o,
    output logic [`PCS_NCOND-1:0] timer_run_o,
    output logic [`PCS_NCOND-1:0] timer_expired_o
);
    localparam int N = `PCS_NCOND;
    // feature enable flag lives in non-volatile state, so no reset touches it
    logic feat_en_r = 1'b0;
    logic supported_r, pm_adv_r, wb7_r;
    logic [7:0] cmd_feat_r, cmd_cnt_r, cmd_sn_r;
    logic [15:0] cmd_tmr_r;
    logic [7:0] err_r, stat_r;
    logic go_r;
    logic [N-1:0] changeable_r, savable_r, supp_r;
    logic [31:0] cur_t_r [N];
    logic [31:0] sav_t_r [N];
    logic [31:0] def_t_r [N];
    logic [N-1:0] cur_en_r, sav_en_r, run_r, exp_r;
    logic [31:0] cnt_r [N];
    logic [31:0] tick_r;
    logic [7:0] sel_r;
    pcs_pkg::pcs_state_e st_r;
    logic aw_ok, w_ok;
    logic [7:0] awaddr_r, araddr_r;
    logic [31:0] wdata_r;
    logic have_aw_r, have_w_r;
    logic [3:0] sub;
    logic id_ok;
    logic [31:0] req_t;
    logic [31:0] clamped;
    logic [31:0] rd;
    logic [$clog2(N)-1:0] idx;

    assign sub = cmd_sn_r[3:0];
    assign idx = cmd_cnt_r[$clog2(N)-1:0];
    assign id_ok = (cmd_cnt_r < 8'(N)) && supp_r[idx];
    // units of a minute are scaled to 100 ms steps
    assign req_t = cmd_sn_r[`PCS_BIT_UNITS] ? 32'(cmd_tmr_r) * `PCS_MIN_TO_UNITS
                                              : 32'(cmd_tmr_r);
    // always clamp, so the out-of-range abort never fires
    assign clamped = (req_t > `PCS_TMR_MAX) ? `PCS_TMR_MAX :
                     (req_t < `PCS_TMR_MIN) ? `PCS_TMR_MIN : req_t;

    // axi write channel: take address and data in either order
    assign aw_ok = s_axi_awvalid && s_axi_awready;
    assign w_ok = s_axi_wvalid && s_axi_wready;
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
            have_aw_r <= 1'b0;
            have_w_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h00000000;
        end else begin
            if (aw_ok) begin
                have_aw_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (w_ok) begin
                have_w_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                s_axi_wready <= 1'b0;
            end
            if (have_aw_r && have_w_r && !s_axi_bvalid) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (awaddr_r > `PCS_ADDR_DATA) ? 2'b10 : 2'b00;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                have_aw_r <= 1'b0;
                have_w_r <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end
    logic wr_fire;
    assign wr_fire = have_aw_r && have_w_r && !s_axi_bvalid;

    // command capture and configuration registers
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            cmd_feat_r <= 8'h00;
            cmd_cnt_r <= 8'h00;
            cmd_sn_r <= 8'h00;
            cmd_tmr_r <= 16'h0000;
            go_r <= 1'b0;
            supported_r <= 1'b1;
            changeable_r <= '1;
            savable_r <= '1;
            supp_r <= '1;
            sel_r <= 8'h00;
        end else begin
            go_r <= 1'b0;
            if (wr_fire && st_r == pcs_pkg::PCS_IDLE) begin
                unique case (awaddr_r)
                    `PCS_ADDR_CMD: begin
                        cmd_feat_r <= wdata_r[7:0];
                        cmd_cnt_r <= wdata_r[15:8];
                        cmd_sn_r <= wdata_r[23:16];
                        go_r <= 1'b1;
                    end
                    `PCS_ADDR_TIMER: cmd_tmr_r <= wdata_r[15:0];
                    `PCS_ADDR_CTRL: supported_r <= wdata_r[0];
                    `PCS_ADDR_COND: begin
                        supp_r <= wdata_r[N-1:0];
                        changeable_r <= wdata_r[N+7:8];
                        savable_r <= wdata_r[N+15:16];
                    end
                    `PCS_ADDR_SEL: sel_r <= wdata_r[7:0];
                    default: ;
                endcase
            end
        end
    end

    logic do_ok, do_abt;
    logic valid_t, valid_s;
    assign valid_t = feat_en_r && id_ok && changeable_r[idx]
                     && !(cmd_sn_r[`PCS_BIT_SAVE] && !savable_r[idx]);
    assign valid_s = feat_en_r && id_ok && changeable_r[idx]
                     && !(cmd_sn_r[`PCS_BIT_SAVE] && !savable_r[idx]);
    always_comb begin
        do_ok = 1'b0;
        unique case (sub)
            `PCS_SUB_TIMER: do_ok = valid_t;
            `PCS_SUB_STATE: do_ok = valid_s;
            `PCS_SUB_ENA: do_ok = supported_r;
            `PCS_SUB_DIS: do_ok = supported_r && feat_en_r;
            default: do_ok = 1'b0;
        endcase
        do_abt = !do_ok;
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            st_r <= pcs_pkg::PCS_IDLE;
            err_r <= 8'h00;
            stat_r <= `PCS_ST_OK;
        end else begin
            unique case (st_r)
                pcs_pkg::PCS_IDLE: if (go_r) begin
                    st_r <= pcs_pkg::PCS_EXEC;
                    stat_r <= `PCS_ST_BSY;
                end
                pcs_pkg::PCS_EXEC: begin
                    st_r <= pcs_pkg::PCS_DONE;
                    err_r <= do_abt ? `PCS_ERR_ABT : 8'h00;
                    stat_r <= do_abt ? `PCS_ST_ERR : `PCS_ST_OK;
                end
                pcs_pkg::PCS_DONE: st_r <= pcs_pkg::PCS_IDLE;
                default: st_r <= pcs_pkg::PCS_IDLE;
            endcase
        end
    end
    logic exec;
    assign exec = (st_r == pcs_pkg::PCS_EXEC) && do_ok;

    // feature enable flag persists through resets; reset clears the identify bit, which is reloaded from the flag on the next cycle
    always_ff @(posedge clock_i) begin
        if (exec && sub == `PCS_SUB_ENA) begin
            feat_en_r <= 1'b1;
        end else if (exec && sub == `PCS_SUB_DIS) begin
            feat_en_r <= 1'b0;
        end
    end
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            wb7_r <= 1'b0;
            pm_adv_r <= 1'b1;
        end else begin
            wb7_r <= feat_en_r;
            if (exec && sub == `PCS_SUB_ENA) begin
                wb7_r <= 1'b1;
                pm_adv_r <= 1'b0;
            end
            if (exec && sub == `PCS_SUB_DIS) wb7_r <= 1'b0;
        end
    end

    // timer settings and timers
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            tick_r <= 32'h00000000;
        end else begin
            tick_r <= (tick_r >= 32'(TICK_CYC - 1)) ? 32'h00000000 : tick_r + 32'h00000001;
        end
    end
    logic tick;
    assign tick = (tick_r == 32'h00000000);
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < N; i++) begin
                cur_t_r[i] <= 32'h00000000;
                sav_t_r[i] <= 32'h00000000;
                def_t_r[i] <= `PCS_TMR_DEF;
                cnt_r[i] <= 32'h00000000;
            end
            cur_en_r <= '0;
            sav_en_r <= '0;
            run_r <= '0;
            exp_r <= '0;
        end else begin
            for (int i = 0; i < N; i++) begin
                if (run_r[i] && tick) begin
                    if (cnt_r[i] <= 32'h00000001) begin
                        run_r[i] <= 1'b0;
                        exp_r[i] <= 1'b1;
                    end
                    cnt_r[i] <= cnt_r[i] - 32'h00000001;
                end
            end
            if (exec) begin
                unique case (sub)
                    `PCS_SUB_TIMER: begin
                        cur_t_r[idx] <= clamped;
                        cur_en_r[idx] <= cmd_sn_r[`PCS_BIT_EN] && clamped != 0;
                        if (cmd_sn_r[`PCS_BIT_SAVE]) begin
                            sav_t_r[idx] <= clamped;
                            sav_en_r[idx] <= cmd_sn_r[`PCS_BIT_EN] && clamped != 0;
                        end
                    end
                    `PCS_SUB_STATE: begin
                        cur_en_r[idx] <= cmd_sn_r[`PCS_BIT_EN];
                        if (cmd_sn_r[`PCS_BIT_SAVE]) sav_en_r[idx] <= cmd_sn_r[`PCS_BIT_EN];
                    end
                    `PCS_SUB_ENA: begin
                        for (int i = 0; i < N; i++) begin
                            cur_t_r[i] <= (sav_t_r[i] == 0) ? def_t_r[i] : sav_t_r[i];
                            cnt_r[i] <= (sav_t_r[i] == 0) ? def_t_r[i] : sav_t_r[i];
                            run_r[i] <= cur_en_r[i]
                                && ((sav_t_r[i] == 0) ? def_t_r[i] : sav_t_r[i]) != 0;
                            exp_r[i] <= 1'b0;
                        end
                    end
                    `PCS_SUB_DIS: run_r <= '0;
                    default: ;
                endcase
            end
        end
    end

    // read channel
    always_comb begin
        unique case (araddr_r)
            `PCS_ADDR_CMD: rd = {8'h00, cmd_sn_r, cmd_cnt_r, cmd_feat_r};
            `PCS_ADDR_TIMER: rd = {16'h0000, cmd_tmr_r};
            `PCS_ADDR_CTRL: rd = {28'h0000000, pm_adv_r, wb7_r, feat_en_r, supported_r};
            `PCS_ADDR_STAT: rd = {16'h0000, err_r, stat_r};
            `PCS_ADDR_COND: rd = {8'h00, 6'h00, savable_r, 6'h00, changeable_r, 6'h00, supp_r};
            `PCS_ADDR_SEL: rd = {24'h000000, sel_r};
            `PCS_ADDR_DATA: rd = {cur_en_r[sel_r[0]], sav_en_r[sel_r[0]], 8'h00,
                                  cur_t_r[sel_r[0]][21:0]};
            default: rd = 32'h00000000;
        endcase
    end
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'b00;
            araddr_r <= 8'h00;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                araddr_r <= s_axi_araddr;
                s_axi_arready <= 1'b0;
            end else if (!s_axi_arready && !s_axi_rvalid) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd;
                s_axi_rresp <= (araddr_r > `PCS_ADDR_DATA) ? 2'b10 : 2'b00;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            id_word120_bit7_o <= 1'b0;
            advanced_power_management_en_o <= 1'b1;
            timer_run_o <= '0;
            timer_expired_o <= '0;
        end else begin
            id_word120_bit7_o <= wb7_r;
            advanced_power_management_en_o <= pm_adv_r;
            timer_run_o <= run_r;
            timer_expired_o <= exp_r;
        end
    end
endmodule : pcs_handler

// [hw/pcs_pkg.sv]
package pcs_pkg;
    typedef enum logic [2:0] {
        PCS_IDLE = 3'b001,
        PCS_EXEC = 3'b010,
        PCS_DONE = 3'b100
    } pcs_state_e;
endpackage : pcs_pkg
